// ===== bench/tb.sv
/*
 * Self-checking bench: both ends joined, app side and line side driven.
 * Assumes the package, interface and design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tx_client_map.svh"

module tb;
    import tx_client_pkg::*;
    logic ref_clk, reset, lanes_in, line_ready, stall, hold_off;
    logic app_valid, app_sop, app_eop, app_error, app_ready;
    logic line_valid, line_sop, line_eop, line_fault, loop_valid, loop_eop, rx_malformed;
    logic [`BUS_BITS-1:0] app_data, line_data, loop_data, d;
    logic [`EMPTY_BITS-1:0] app_empty, line_empty;
    logic [65:0] line_block;
    logic [31:0] seed = 32'h0000004F;
    logic [31:0] st = 32'h0000004F;
    logic [31:0] r;
    ipg_mode_type ipg_mode;
    beat_type got;
    beat_type exp_q[$];
    int fails = 0;
    int checked = 0;
    int owed = 0;
    int owed_max = 3;
    ipg_mode_type line_mode = IPG_AVG12;

    tx_client_if tx_client_if_inst ();
    tx_client_end tx_client_end_inst (.ref_clk(ref_clk), .reset(reset),
        .link(tx_client_if_inst), .app_data(app_data), .app_valid(app_valid),
        .app_sop(app_sop), .app_eop(app_eop), .app_empty(app_empty),
        .app_error(app_error), .app_ready(app_ready));
    tx_mac_end tx_mac_end_inst (.ref_clk(ref_clk), .reset(reset),
        .link(tx_client_if_inst), .ipg_mode(ipg_mode), .lanes_stable(lanes_in),
        .line_ready(line_ready), .line_data(line_data), .line_valid(line_valid),
        .line_sop(line_sop), .line_eop(line_eop), .line_empty(line_empty),
        .line_fault(line_fault), .line_block(line_block), .loop_data(loop_data),
        .loop_valid(loop_valid), .loop_eop(loop_eop), .rx_malformed(rx_malformed));
    tx_link_assertions tx_link_assertions_inst (.ref_clk(ref_clk), .reset(reset),
        .data(tx_client_if_inst.data), .valid(tx_client_if_inst.valid),
        .ready(tx_client_if_inst.ready), .sop(tx_client_if_inst.sop),
        .eop(tx_client_if_inst.eop), .empty(tx_client_if_inst.empty),
        .error(tx_client_if_inst.error), .lanes_stable(tx_client_if_inst.lanes_stable));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] rnd();
        seed = lfsr(seed);
        return seed;
    endfunction

    // what the line must carry for a staged word
    function automatic logic [`BUS_BITS-1:0] line_word(input beat_type b);
        if (b.eop && b.error)
            return {32{8'h1E}};
        if (b.eop)
            return b.data & ({`BUS_BITS{1'b1}} << (8 * b.empty));
        return b.data;
    endfunction

    // gap bytes still owed after an end word; surplus gap is never banked
    function automatic int gap_owed(input ipg_mode_type m, input int owed_in, input int empty);
        int t;
        t = (m == IPG_AVG8) ? `GAP_AVG8_BYTES
            : (m == IPG_OFF) ? `GAP_MIN_BYTES : `GAP_AVG12_BYTES;
        t = t + owed_in - empty;
        return (t > 0) ? t : 0;
    endfunction

    task automatic check(input string what, input logic [299:0] exp, input logic [299:0] seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic put_word(input beat_type b);
        int n = 0;
        @(negedge ref_clk);
        {app_data, app_sop, app_eop, app_empty, app_error} = b;
        app_valid = 1'b1;
        while (app_ready !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
    endtask

    task automatic send_pkt(input int words, input logic [4:0] e, input logic err);
        beat_type b;
        for (int i = 0; i < words; i++) begin
            b.data = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            b.sop = (i == 0);
            b.eop = (i == words - 1);
            b.empty = b.eop ? e : 5'h00;
            b.error = b.eop & err;
            put_word(b);
            if (words > 1 || e < 5'h18)
                exp_q.push_back(b);
        end
        @(negedge ref_clk);
        app_valid = 1'b0;
    endtask

    task automatic loop_word(input logic [`BUS_BITS-1:0] w, input logic exp);
        @(negedge ref_clk);
        {loop_data, loop_valid, loop_eop} = {w, 2'h3};
        @(negedge ref_clk);
        {loop_valid, loop_eop} = 2'h0;
        check("malformed flag", exp, rx_malformed);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // line stalls: a quarter at random, plus one forced burst that fills the buffer
    always @(negedge ref_clk) begin
        st = lfsr(st);
        line_ready = !hold_off && (!stall || st[0] || st[1]);
    end

    // an idle line cycle carries a full bus of gap bytes
    always @(posedge ref_clk) begin
        if (!reset && line_ready === 1'b1 && line_valid !== 1'b1)
            owed = 0;
        if (!reset && line_valid === 1'b1 && line_ready === 1'b1) begin
            got = exp_q.pop_front();
            if (got.sop)
                check("gap owed", 1'b1, owed <= owed_max);
            if (got.eop) begin
                owed = gap_owed(line_mode, owed, got.empty);
                owed_max = (line_mode == IPG_OFF) ? 0 : `DEFICIT_MAX;
            end
            check("line data", line_word(got), line_data);
            check("line marks", {got.sop, got.eop, got.empty, got.error},
                {line_sop, line_eop, line_empty, line_fault});
            check("fault block", got.error ? `FAULT_BLOCK : 66'h0, line_block);
        end
        // the shown word was loaded, and its gap chosen, at the last edge with line_ready
        if (line_ready === 1'b1)
            line_mode = ipg_mode;
    end

    // about 300 cycles of traffic expected; twenty times that is a hang
    initial begin
        #(40 * 6000);
        fails++;
        end_of_test();
    end

    initial begin
        {app_valid, app_sop, app_eop, app_error, app_data, app_empty} = '0;
        {loop_valid, loop_eop, loop_data, stall, hold_off, lanes_in} = '0;
        ipg_mode = IPG_AVG12;
        reset = 1'b1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        send_pkt(2, 5'h03, 1'b0);
        repeat (20) @(negedge ref_clk);
        check("words before lanes", 2, exp_q.size());
        lanes_in = 1'b1;
        for (int m = 0; m < 3; m++) begin
            ipg_mode = ipg_mode_type'(m);
            for (int k = 0; k < 4; k++) begin
                r = rnd();
                send_pkt(2 + r[1:0], (k == 0) ? 5'h00 : r[8:4], k == 2);
                stall = (k > 0);
            end
        end
        send_pkt(1, 5'h17, 1'b1);
        send_pkt(1, 5'h18, 1'b0);
        send_pkt(3, 5'h1F, 1'b0);
        // the stall holds the end word until the next start is buffered behind it
        fork
            begin
                send_pkt(8, 5'h00, 1'b1);
                send_pkt(1, 5'h17, 1'b0);
            end
            begin
                @(posedge tx_client_if_inst.error);
                hold_off = 1'b1;
                repeat (10) @(negedge ref_clk);
                hold_off = 1'b0;
            end
        join
        d = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        loop_word(d, 1'b0);
        d[191:128] = {8{8'h1E}};
        loop_word(d, 1'b1);
        for (int n = 0; n < 200 && exp_q.size() > 0; n++)
            @(negedge ref_clk);
        check("words left", 0, exp_q.size());
        end_of_test();
    end
endmodule // tb

`default_nettype wire

// ===== bench/tx_link_assertions.sv
/*
 * Assertions and covers on the client link joining both ends.
 * Assumes one clock and a synchronous active-high reset; the bench
 * instantiates it beside the interface.
 */
`include "tx_client_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tx_link_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // client link
    input wire logic [`BUS_BITS-1:0] data,
    input wire logic valid,
    input wire logic ready,
    input wire logic sop,
    input wire logic eop,
    input wire logic [`EMPTY_BITS-1:0] empty,
    input wire logic error,
    input wire logic lanes_stable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // inside a packet once a non-end word has been taken
    logic in_pkt;
    wire logic take = valid && ready;
    always_ff @(posedge ref_clk) begin
        if (reset)
            in_pkt <= 1'b0;
        else if (take)
            in_pkt <= !eop;
    end

    ////////////////////////////////////////////////////////////////////////
    AST_ERR_AT_EOP: assert property (valid && error |-> eop)
        else $error("error flag outside end word");
    AST_HOLD_VALID: assert property (valid && !ready |=> valid)
        else $error("valid dropped before accept");
    AST_HOLD_WORD: assert property (valid && !ready |=> $stable(data) && $stable(empty))
        else $error("word changed while refused");
    AST_HOLD_MARKS: assert property (valid && !ready |=> $stable({sop, eop, error}))
        else $error("markers changed while refused");
    AST_NO_IDLE_IN_PKT: assert property (in_pkt |-> valid)
        else $error("idle cycle inside packet");
    AST_SOP_OPENS: assert property (valid && !in_pkt |-> sop)
        else $error("packet opened without start marker");
    AST_EMPTY_MID: assert property (valid && !eop |-> empty == 5'h00)
        else $error("empty count outside end word");
    AST_LANES_FIRST: assert property (valid |-> lanes_stable)
        else $error("word offered before lanes stable");
    AST_RESET_QUIET: assert property ($fell(reset) |-> !valid && ready)
        else $error("link busy right after reset");

    COV_SHORT_PKT: cover property (take && sop && eop);
    COV_REFUSED: cover property (valid && !ready);
    COV_FAULT: cover property (take && error);
    COV_EMPTY_END: cover property (take && eop && empty != 5'h00);
endmodule // tx_link_assertions

`default_nettype wire

// ===== common/tx_client_if.sv
/*
 * Wide transmit client link between client logic (source) and MAC (sink).
 * Assumes both ends run on the one transmit clock given by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tx_client_map.svh"

interface tx_client_if;
    logic [`BUS_BITS-1:0] data;
    logic valid;
    logic ready;
    logic sop;
    logic eop;
    logic [`EMPTY_BITS-1:0] empty;
    logic error;
    logic lanes_stable;

    modport client (
        output data, valid, sop, eop, empty, error,
        input ready, lanes_stable
    );

    modport mac (
        input data, valid, sop, eop, empty, error,
        output ready, lanes_stable
    );
endinterface

`default_nettype wire

// ===== common/tx_client_map.svh
/*
 * Constants of the transmit client path: gap targets, bus geometry,
 * fault block layout and the client staging depth.
 * Assumes it is included by bare name; holds definitions only.
 */
// Contract
// (RQ1) Setting twelve: deficit counter keeps 12-byte average.
// (RQ2) Setting eight: average gap at least 8 bytes.
// (RQ3) Counter off: send at once, 1-byte gap.
// (RQ4) Injected error is one 66-bit block.
// (RQ5) Flagged packet's end word carries the block.
// (RQ6) Wide bus: request only in end cycle.
// (RQ7) Narrow bus: request bit N with end bit N.
// (RQ8) Looped-back corrupted packet counts as malformed.
// (RQ9) Bus 128 or 256 bits at 312.5 MHz.
// (RQ10) First packet byte sits in top byte.
// (RQ11) Word taken in same cycle as accept.
// (RQ12) Client drives valid, waits for accept.
// (RQ13) Client holds word while accept low.
// (RQ14) Valid stays high from start to end.
// (RQ15) Client buffers so packet runs back to back.
// (RQ16) End cycle carries 5-bit unused byte count.
// (RQ17) Preamble pass-through: packet opens with preamble.
// (RQ18) Client never sends frames under nine bytes.
// (RQ19) Client waits for lanes stable after reset.
// (RQ20) All signals on the transmit clock.
// (RQ21) Narrow bus flag bit 0 means low word.
// (RQ22) Only the flagged packet is corrupted.
`ifndef TX_CLIENT_MAP_SVH
`define TX_CLIENT_MAP_SVH

`define BUS_BITS 256
`define BUS_BYTES 6'h20
`define EMPTY_BITS 5
`define NARROW_BUS_BITS 128
`define LINK_MHZ_X10 3125
`define GAP_AVG12_BYTES 6'h0C
`define GAP_AVG12_BITS 96
`define GAP_AVG8_BYTES 6'h08
`define GAP_MIN_BYTES 6'h01
`define DEFICIT_MAX 6'h03
`define MIN_FRAME_BYTES 6'h09
`define ERR_CHAR 8'h1E
`define FAULT_BLOCK {2'h2, 8'h1E, {8{7'h1E}}}
`define FAULT_LANE {8{8'h1E}}
`define STAGE_DEPTH 64
`define STAGE_PTR_BITS 6

`endif

// ===== common/tx_client_pkg.sv
/*
 * Types shared by both ends of the transmit client link.
 * Assumes tx_client_map.svh is on the include path.
 */
`include "tx_client_map.svh"

package tx_client_pkg;

    typedef enum logic [1:0] {
        IPG_AVG12 = 2'h0,
        IPG_AVG8 = 2'h1,
        IPG_OFF = 2'h2
    } ipg_mode_type;

    typedef enum logic [2:0] {
        MAC_RUN = 3'h1,
        MAC_GAP = 3'h2,
        MAC_SPARE = 3'h4
    } mac_state_type;

    typedef enum logic [2:0] {
        CL_LOAD = 3'h1,
        CL_PEND = 3'h2,
        CL_SEND = 3'h4
    } client_state_type;

    typedef struct packed {
        logic [`BUS_BITS-1:0] data;
        logic sop;
        logic eop;
        logic [`EMPTY_BITS-1:0] empty;
        logic error;
    } beat_type;

endpackage

// ===== verilog/two_slot_buffer.sv
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module two_slot_buffer #(
    parameter int WIDTH = 264
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic wr;
        logic rd;
        logic [1:0] count;
        logic room;
    } buf_state_type;

    buf_state_type s;
    buf_state_type next_s;
    logic take;
    logic give;

    assign in_ready = s.room;
    assign out_valid = (s.count != 2'h0);
    assign out_data = s.slot[s.rd];
    assign take = in_valid && s.room;
    assign give = out_ready && out_valid;

    always_comb begin
        next_s = s;
        if (take) begin
            next_s.slot[s.wr] = in_data;
            next_s.wr = ~s.wr;
        end
        if (give) begin
            next_s.rd = ~s.rd;
        end
        case ({take, give})
            2'h2: next_s.count = s.count + 2'h1;
            2'h1: next_s.count = s.count - 2'h1;
            default: next_s.count = s.count;
        endcase
        // room is registered so the sink's ready comes from a flop
        next_s.room = (next_s.count != 2'h2);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s <= '0;
            s.room <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

endmodule // two_slot_buffer

`default_nettype wire

// ===== verilog/tx_client_end.sv
/*
 * Client end of the transmit client link: stages a whole packet, waits for
 * stable lanes, then plays it out back to back under accept.
 * Assumes app words arrive MSB-first; packets up to 64 words.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tx_client_map.svh"

module tx_client_end
    import tx_client_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // client link
    tx_client_if.client link,
    // application side
    input wire logic [`BUS_BITS-1:0] app_data,
    input wire logic app_valid,
    input wire logic app_sop,
    input wire logic app_eop,
    input wire logic [`EMPTY_BITS-1:0] app_empty,
    input wire logic app_error,
    output logic app_ready
);

    typedef struct packed {
        client_state_type state;
        logic [`STAGE_PTR_BITS-1:0] wr;
        logic [`STAGE_PTR_BITS-1:0] rd;
        logic [`STAGE_PTR_BITS-1:0] last;
        logic [`EMPTY_BITS-1:0] last_empty;
        logic last_error;
        logic ready;
        beat_type out;
        logic valid;
    } client_reg_type;

    client_reg_type s;
    client_reg_type next_s;
    logic [`BUS_BITS-1:0] stage [`STAGE_DEPTH];
    logic take;
    logic short_frame;
    logic [`STAGE_PTR_BITS-1:0] pick;

    assign take = app_valid && s.ready;
    // a lone word with fewer than nine live bytes is dropped
    assign short_frame = (s.wr == '0 || app_sop)
        && ((`BUS_BYTES - {1'b0, app_empty}) < `MIN_FRAME_BYTES); // [RQ18]

    always_ff @(posedge ref_clk) begin
        if (take) begin
            stage[app_sop ? '0 : s.wr] <= app_data; // [RQ17] [RQ10]
        end
    end

    always_comb begin
        next_s = s;
        pick = s.rd;
        case (s.state)
            CL_LOAD: begin
                if (take) begin
                    next_s.wr = (app_sop ? '0 : s.wr) + 1'b1;
                    // limitation: a 64th word without end is taken as the end
                    if (app_eop || next_s.wr == '0) begin
                        next_s.last = app_sop ? '0 : s.wr;
                        next_s.last_empty = app_empty; // [RQ16]
                        next_s.last_error = app_error;
                        next_s.wr = '0;
                        if (!(app_eop && short_frame)) begin
                            next_s.state = CL_PEND; // [RQ15]
                        end
                    end
                end
            end
            CL_PEND: begin
                if (link.lanes_stable) begin // [RQ19]
                    pick = '0;
                    next_s.rd = '0;
                    next_s.valid = 1'b1; // [RQ12]
                    next_s.out.sop = 1'b1;
                    next_s.state = CL_SEND;
                end
            end
            CL_SEND: begin
                // word is held until accepted, with no gaps inside a packet
                if (link.ready) begin // [RQ13] [RQ14]
                    if (s.out.eop) begin
                        next_s.valid = 1'b0;
                        next_s.out.sop = 1'b0;
                        next_s.state = CL_LOAD;
                    end else begin
                        pick = s.rd + 1'b1;
                        next_s.rd = pick;
                        next_s.out.sop = 1'b0;
                    end
                end
            end
            default: begin
                next_s.state = CL_LOAD;
            end
        endcase
        next_s.out.data = stage[pick];
        next_s.out.eop = next_s.valid && (pick == s.last);
        // error and empty only ever ride on the end word
        next_s.out.empty = next_s.out.eop ? s.last_empty : '0; // [RQ16]
        next_s.out.error = next_s.out.eop && s.last_error; // [RQ6]
        next_s.ready = (next_s.state == CL_LOAD);
    end

    always_ff @(posedge ref_clk) begin // [RQ20]
        if (reset) begin
            s <= '0;
            s.state <= CL_LOAD;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // the wide variant is built here; the narrow variant would pair flag
    // bit 0 with the low 64-bit word and bit N of error with end bit N
    assign link.data = s.out.data; // [RQ9] [RQ21] [RQ7]
    assign link.valid = s.valid;
    assign link.sop = s.out.sop;
    assign link.eop = s.out.eop;
    assign link.empty = s.out.empty;
    assign link.error = s.out.error;
    assign app_ready = s.ready;

endmodule // tx_client_end

`default_nettype wire

// ===== verilog/tx_mac_end.sv
/*
 * MAC end of the transmit client link: zero-latency sink, gap
 * enforcement with a deficit idle counter, fault block insertion and a
 * loopback malformed-packet detector.
 * Assumes the line side (toward the PCS) may stall through line_ready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tx_client_map.svh"

module tx_mac_end
    import tx_client_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // client link
    tx_client_if.mac link,
    // configuration and status from the phy
    input wire ipg_mode_type ipg_mode,
    input wire logic lanes_stable,
    // line side
    input wire logic line_ready,
    output logic [`BUS_BITS-1:0] line_data,
    output logic line_valid,
    output logic line_sop,
    output logic line_eop,
    output logic [`EMPTY_BITS-1:0] line_empty,
    output logic line_fault,
    output logic [65:0] line_block,
    // loopback receive classification
    input wire logic [`BUS_BITS-1:0] loop_data,
    input wire logic loop_valid,
    input wire logic loop_eop,
    output logic rx_malformed
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        mac_state_type state;
        logic [5:0] debt;
        logic stable;
        logic [`BUS_BITS-1:0] data;
        logic valid;
        logic sop;
        logic eop;
        logic [`EMPTY_BITS-1:0] empty;
        logic fault;
        logic [65:0] block;
        logic malformed;
    } mac_reg_type;

    localparam mac_reg_type MAC_RESET = '{
        state: MAC_RUN,
        debt: 6'h00,
        stable: 1'b0,
        data: '0,
        valid: 1'b0,
        sop: 1'b0,
        eop: 1'b0,
        empty: '0,
        fault: 1'b0,
        block: '0,
        malformed: 1'b0
    };

    mac_reg_type s;
    mac_reg_type next_s;

    ////////////////////////////////////////////////////////////////////////
    // input staging: a stall on the line side fills this and drops ready

    beat_type in_beat;
    beat_type head;
    logic head_valid;
    logic head_pop;
    logic buf_ready;

    always_comb begin
        in_beat.data = link.data; // [RQ10]
        in_beat.sop = link.sop;
        in_beat.eop = link.eop;
        in_beat.empty = link.empty; // [RQ16]
        in_beat.error = link.error && link.eop; // [RQ6]
    end

    two_slot_buffer #(
        .WIDTH($bits(beat_type))
    ) u_stage (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_data(in_beat),
        .in_valid(link.valid), // [RQ11] [RQ20]
        .in_ready(buf_ready),
        .out_data(head),
        .out_valid(head_valid),
        .out_ready(head_pop)
    );

    // word taken whenever valid and ready meet in one cycle
    assign link.ready = buf_ready; // [RQ11]
    assign link.lanes_stable = s.stable; // [RQ19]

    ////////////////////////////////////////////////////////////////////////
    // gap targets

    logic [5:0] target;
    logic deficit_on;
    logic [5:0] need;
    logic [`BUS_BITS-1:0] keep_mask;
    logic loop_hit;

    always_comb begin
        case (ipg_mode)
            IPG_AVG12: target = `GAP_AVG12_BYTES; // [RQ1]
            IPG_AVG8: target = `GAP_AVG8_BYTES; // [RQ2]
            IPG_OFF: target = `GAP_MIN_BYTES; // [RQ3]
            default: target = `GAP_AVG12_BYTES;
        endcase
    end

    assign deficit_on = (ipg_mode != IPG_OFF); // [RQ3]

    // bytes of gap still owed after this word; trailing empty bytes of the
    // end word already count as gap; with the counter on, up to 3 owed bytes carry forward
    assign need = target + s.debt - {1'b0, head.empty}; // [RQ1] [RQ2]

    // unused trailing bytes are blanked so they never reach the line
    assign keep_mask = {`BUS_BITS{1'b1}} << {head.empty, 3'h0}; // [RQ16]

    always_comb begin
        loop_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (loop_data[i*64 +: 64] == `FAULT_LANE) begin
                loop_hit = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit engine

    assign head_pop = line_ready && head_valid && (s.state == MAC_RUN);

    always_comb begin
        next_s = s;
        next_s.stable = lanes_stable;
        // a corrupted end word coming back in loopback is flagged malformed
        next_s.malformed = loop_valid && loop_eop && loop_hit; // [RQ8]
        if (line_ready) begin
            next_s.valid = 1'b0;
            next_s.sop = 1'b0;
            next_s.eop = 1'b0;
            next_s.fault = 1'b0;
            next_s.block = '0;
            case (s.state)
                MAC_RUN: begin
                    if (head_valid) begin
                        next_s.valid = 1'b1;
                        next_s.sop = head.sop;
                        next_s.eop = head.eop;
                        next_s.empty = head.eop ? head.empty : '0;
                        next_s.data = head.eop ? (head.data & keep_mask) : head.data;
                        // only the end word of the flagged packet is replaced
                        if (head.eop && head.error) begin // [RQ5] [RQ22]
                            next_s.data = {4{`FAULT_LANE}}; // [RQ4]
                            next_s.fault = 1'b1;
                            next_s.block = `FAULT_BLOCK; // [RQ4]
                        end
                        if (head.eop) begin
                            if (need[5] || need == 6'h00) begin
                                // surplus gap is not banked so the average
                                // never drops below the target
                                next_s.debt = 6'h00;
                            end else if (deficit_on && need <= `DEFICIT_MAX) begin
                                next_s.debt = need; // [RQ1] [RQ2]
                            end else begin
                                // one idle word gives a full bus of gap bytes
                                next_s.debt = 6'h00;
                                next_s.state = MAC_GAP; // [RQ3]
                            end
                        end
                    end
                end
                MAC_GAP: begin
                    next_s.state = MAC_RUN;
                end
                default: begin
                    next_s.state = MAC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s <= MAC_RESET;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign line_data = s.data;
    assign line_valid = s.valid;
    assign line_sop = s.sop;
    assign line_eop = s.eop;
    assign line_empty = s.empty;
    assign line_fault = s.fault;
    assign line_block = s.block;
    assign rx_malformed = s.malformed;

endmodule // tx_mac_end

`default_nettype wire
